// *** core/pwm_tb_consts.svh ***
`ifndef PWM_TB_CONSTS_SVH
`define PWM_TB_CONSTS_SVH
// byte offsets on the register bus
`define OFF_TB_CTRL    8'h00
`define OFF_CLK_DIV    8'h04
`define OFF_PERIOD     8'h08
`define OFF_SEV_CMP    8'h0c
`define OFF_KEY        8'h10
`define OFF_OVERRIDE   8'h14
`define OFF_FLT_LIMIT  8'h18
`define OFF_STATUS     8'h1c
`define OFF_COUNT      8'h20
// time-base control field positions
`define B_ENABLE       15
`define B_IDLE_STOP    13
`define B_SEV_FLAG     12
`define B_SEV_IEN      11
`define B_IMM_PER      10
`define B_SYNC_POL     9
`define B_SYNC_OEN     8
`define B_SYNC_IEN     7
// fault/limit control: fault_mode_sel in bits 1:0, fault enable bit 2, latch clear bit 3
`define B_FLT_EN       2
`define B_FLT_CLR      3
// reset values, unlock keys and sync source codes
`define RST_TB_CTRL    16'h0000
`define RST_PERIOD     16'hfff8
`define RST_FLT_LIMIT  16'h0004
`define KEY_FIRST      16'habcd
`define KEY_SECOND     16'h4321
`define SRC_PIN        3'h0
`define SRC_TRIG_A     3'h2
`define SRC_TRIG_B     3'h3
`endif

// *** core/pwm_tb_pkg.sv ***
package pwm_tb_pkg;
   typedef enum logic [1:0] {
      KEY_IDLE  = 2'b00,
      KEY_ONE   = 2'b01,
      KEY_OPEN  = 2'b11
   } key_state_e;
endpackage : pwm_tb_pkg

// *** core/pwm_master_time_base_ctrl.sv ***
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_tb_consts.svh"
// Summary of operation
// - sync input realigns the time base; sync output pulses at each period end
// - an active fault forces all PWM outputs to the safe state
// - reset leaves the safety fault enabled and latched
// - fault mode field writes accepted whatever the fault pin level
// - protect config 1 guards override and fault registers, 0 leaves them open
// - the protected write must be the next register access after the keys
// - one unlock permits exactly one protected write
// - enable bit 15 runs the module, 0 disables it
// - idle-stop bit 13 halts the time base in cpu idle
// - bit 12 flags pending special event, bit 11 enables that interrupt
// - bit 10 loads period at once, else at cycle boundaries
// - bit 9 makes both sync pins active low
// - bit 8 enables sync output, bit 7 enables sync input
// - source field 000 pin, 010 and 011 trigger outputs, rest reserved
// - special trigger on every (postscale+1)th compare match
// - prescaler divides by 2 to the code, 111 reserved
// - special trigger when count equals the 16-bit compare value
// - the time base counts up to the 16-bit period value
module pwm_master_time_base_ctrl
   import pwm_tb_pkg::*;
(
   // bus clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // device configuration and cpu state
   input  wire logic        write_protect_cfg,
   input  wire logic        cpu_idle,
   // sync pins and trigger sources
   input  wire logic        ext_sync_in,
   input  wire logic        trig_gen_out_a,
   input  wire logic        trig_gen_out_b,
   output logic             ext_sync_out,
   output logic             ext_sync_out_oe_n,
   // fault pin and outputs
   input  wire logic        safety_fault_pin,
   output logic             pwm_run,
   output logic             pwm_safe,
   output logic             special_event_trig,
   output logic             special_event_irq
);
   typedef struct packed {
      logic [15:0] ctrl;
      logic [2:0]  div;
      logic [15:0] period;
      logic [15:0] per_act;
      logic [15:0] sevcmp;
      logic [15:0] ovr;
      logic [15:0] flt;
      logic        flt_latch;
      key_state_e  key;
      logic [15:0] cnt;
      logic [5:0]  pre;
      logic [3:0]  post;
      logic [2:0]  s_sync;
      logic [2:0]  s_flt;
      logic        sync_prev;
      logic        sync_o;
      logic        trig;
      logic        ph_act;
      logic        ph_wr;
      logic [7:0]  ph_addr;
      logic [31:0] rdata;
   } state_s;

   state_s s_q, s_d;
   logic sync_lvl, fault_act, tick, wrap, cmp_hit, unlocked, acc;
   logic [5:0] div_mask;

   assign sync_lvl  = s_q.s_sync[2] ^ s_q.ctrl[`B_SYNC_POL];
   assign fault_act = ~s_q.s_flt[2];
   // pin synchronisers: only the last flop of each chain feeds logic
   assign div_mask  = (s_q.div == 3'h7) ? 6'h00 : 6'((7'h01 << s_q.div) - 7'h01);
   assign tick      = s_q.ctrl[`B_ENABLE] && (s_q.pre & div_mask) == 6'h00
                      && !(s_q.ctrl[`B_IDLE_STOP] && cpu_idle);
   assign wrap      = s_q.cnt >= s_q.per_act;
   assign cmp_hit   = tick && s_q.cnt == s_q.sevcmp;
   assign unlocked  = !write_protect_cfg || s_q.key == KEY_OPEN;
   assign acc       = hsel && hready && htrans[1];

   always_comb begin
      logic ext_sync, sync_edge;
      logic [15:0] wd;
      s_d = s_q;
      ext_sync = 1'b0;
      sync_edge = 1'b0;
      wd = hwdata[15:0];
      s_d.s_sync = {s_q.s_sync[1:0], ext_sync_in};
      s_d.s_flt  = {s_q.s_flt[1:0], safety_fault_pin};
      unique case (s_q.ctrl[6:4])
         `SRC_PIN:    ext_sync = sync_lvl;
         `SRC_TRIG_A: ext_sync = trig_gen_out_a;
         `SRC_TRIG_B: ext_sync = trig_gen_out_b;
         default:     ext_sync = 1'b0;
      endcase
      s_d.sync_prev = ext_sync;
      sync_edge = ext_sync && !s_q.sync_prev && s_q.ctrl[`B_SYNC_IEN];
      s_d.trig = 1'b0;
      s_d.sync_o = 1'b0;
      if (s_q.ctrl[`B_ENABLE])
         s_d.pre = s_q.pre + 6'h01;
      else
         s_d.pre = 6'h00;
      if (s_q.ctrl[`B_IMM_PER])
         s_d.per_act = s_q.period;
      // nothing runs while off, so a stale active period never survives enabling
      if (!s_q.ctrl[`B_ENABLE])
         s_d.per_act = s_q.period;
      if (!s_q.ctrl[`B_ENABLE]) begin
         s_d.cnt = 16'h0000;
      end else if (sync_edge) begin
         s_d.cnt = 16'h0000;
      end else if (tick) begin
         if (wrap) begin
            s_d.cnt = 16'h0000;
            s_d.per_act = s_q.period;
            s_d.sync_o = 1'b1;
         end else
            s_d.cnt = s_q.cnt + 16'h0001;
      end
      if (cmp_hit) begin
         if (s_q.post == s_q.ctrl[3:0]) begin
            s_d.post = 4'h0;
            s_d.trig = 1'b1;
         end else
            s_d.post = s_q.post + 4'h1;
      end
      if (!s_q.ctrl[`B_ENABLE])
         s_d.post = 4'h0;
      // latched fault: set wins over the software clear
      if (s_q.flt[`B_FLT_EN] && fault_act)
         s_d.flt_latch = 1'b1;
      // data phase of a write
      if (s_q.ph_act && s_q.ph_wr) begin
         unique case (s_q.ph_addr)
            `OFF_TB_CTRL: begin
               s_d.ctrl = {wd[15], 1'b0, wd[13], s_q.ctrl[`B_SEV_FLAG], wd[11:0]};
            end
            `OFF_CLK_DIV:  s_d.div = wd[2:0];
            `OFF_PERIOD:   s_d.period = wd;
            `OFF_SEV_CMP:  s_d.sevcmp = wd;
            `OFF_OVERRIDE: if (unlocked) s_d.ovr = wd;
            `OFF_FLT_LIMIT: if (unlocked) begin
               s_d.flt = {wd[15:4], 1'b0, wd[2:0]};
               if (wd[`B_FLT_CLR] && !fault_act)
                  s_d.flt_latch = 1'b0;
            end
            default: ;
         endcase
      end
      // key state moves only in data phases; any other access breaks it
      if (s_q.ph_act && s_q.ph_wr && s_q.ph_addr == `OFF_KEY) begin
         if (s_q.key == KEY_IDLE && wd == `KEY_FIRST)
            s_d.key = KEY_ONE;
         else if (s_q.key == KEY_ONE && wd == `KEY_SECOND)
            s_d.key = KEY_OPEN;
         else
            s_d.key = KEY_IDLE;
      end else if (s_q.ph_act) begin
         s_d.key = KEY_IDLE;
      end
      // special event flag: hardware set, cleared when interrupt disabled
      if (s_q.trig && s_d.ctrl[`B_SEV_IEN])
         s_d.ctrl[`B_SEV_FLAG] = 1'b1;
      else if (!s_d.ctrl[`B_SEV_IEN])
         s_d.ctrl[`B_SEV_FLAG] = 1'b0;
      // address phase capture and read data
      s_d.ph_act  = acc;
      s_d.ph_wr   = hwrite;
      s_d.ph_addr = haddr;
      if (acc && !hwrite) begin
         unique case (haddr)
            `OFF_TB_CTRL:   s_d.rdata = {16'h0000, s_q.ctrl};
            `OFF_CLK_DIV:   s_d.rdata = {29'h0, s_q.div};
            `OFF_PERIOD:    s_d.rdata = {16'h0000, s_q.period};
            `OFF_SEV_CMP:   s_d.rdata = {16'h0000, s_q.sevcmp};
            `OFF_OVERRIDE:  s_d.rdata = {16'h0000, s_q.ovr};
            `OFF_FLT_LIMIT: s_d.rdata = {16'h0000, s_q.flt};
            `OFF_STATUS:    s_d.rdata = {28'h0, s_q.key == KEY_OPEN, fault_act,
                                         s_q.flt_latch, pwm_safe};
            `OFF_COUNT:     s_d.rdata = {16'h0000, s_q.cnt};
            default:        s_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
         s_q.ctrl <= `RST_TB_CTRL;
         s_q.period <= `RST_PERIOD;
         s_q.per_act <= `RST_PERIOD;
         s_q.flt <= `RST_FLT_LIMIT;
         s_q.flt_latch <= 1'b1;
         s_q.key <= KEY_IDLE;
         s_q.s_flt <= 3'h0;
      end else begin
         s_q <= s_d;
      end
   end

   assign hrdata    = s_q.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign ext_sync_out = s_q.sync_o ^ s_q.ctrl[`B_SYNC_POL];
   assign ext_sync_out_oe_n = ~s_q.ctrl[`B_SYNC_OEN];
   assign pwm_safe  = s_q.flt_latch;
   assign pwm_run   = s_q.ctrl[`B_ENABLE] && !s_q.flt_latch;
   assign special_event_trig = s_q.trig;
   assign special_event_irq  = s_q.ctrl[`B_SEV_FLAG];

   property p_fault_latch;
      @(posedge hclk) disable iff (!hresetn)
      (s_q.flt[`B_FLT_EN] && fault_act) |=> pwm_safe && !pwm_run;
   endproperty
   a_fault_latch: assert property (p_fault_latch) else $error("fault not latched");
   property p_disabled_zero;
      @(posedge hclk) disable iff (!hresetn)
      !s_q.ctrl[`B_ENABLE] |=> s_q.cnt == 16'h0000;
   endproperty
   a_disabled_zero: assert property (p_disabled_zero) else $error("count ran while off");
   property p_idle_hold;
      @(posedge hclk) disable iff (!hresetn)
      (s_q.ctrl[`B_ENABLE] && s_q.ctrl[`B_IDLE_STOP] && cpu_idle && !s_q.ph_act)
         |=> $stable(s_q.cnt) || s_q.cnt == 16'h0000;
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("count moved in idle");
   property p_flag_needs_ien;
      @(posedge hclk) disable iff (!hresetn)
      s_q.ctrl[`B_SEV_FLAG] |-> s_q.ctrl[`B_SEV_IEN];
   endproperty
   a_flag_needs_ien: assert property (p_flag_needs_ien) else $error("flag without enable");
   property p_cmp;
      @(posedge hclk) disable iff (!hresetn)
      s_q.trig |-> $past(s_q.cnt) == s_q.sevcmp;
   endproperty
   a_cmp: assert property (p_cmp) else $error("trigger off compare");
   property p_count_max;
      @(posedge hclk) disable iff (!hresetn)
      (tick && wrap) |=> s_q.cnt == 16'h0000;
   endproperty
   a_count_max: assert property (p_count_max) else $error("count past period");
   property p_oe;
      @(posedge hclk) disable iff (!hresetn)
      ext_sync_out_oe_n == !s_q.ctrl[`B_SYNC_OEN];
   endproperty
   a_oe: assert property (p_oe) else $error("sync out drive wrong");
   property p_locked;
      @(posedge hclk) disable iff (!hresetn)
      (s_q.ph_act && s_q.ph_wr && s_q.ph_addr == `OFF_OVERRIDE && !unlocked) |=> $stable(s_q.ovr);
   endproperty
   a_locked: assert property (p_locked) else $error("locked write took");
   property p_one_shot;
      @(posedge hclk) disable iff (!hresetn)
      (s_q.ph_act && s_q.key == KEY_OPEN) |=> s_q.key != KEY_OPEN;
   endproperty
   a_one_shot: assert property (p_one_shot) else $error("unlock reused");
   c_trig: cover property (@(posedge hclk) s_q.trig);
   c_unlock: cover property (@(posedge hclk) s_q.key == KEY_OPEN);
   c_sync: cover property (@(posedge hclk) s_q.sync_o);
   c_fault: cover property (@(posedge hclk) fault_act && s_q.flt_latch);
   c_idle: cover property (@(posedge hclk) s_q.ctrl[`B_IDLE_STOP] && cpu_idle);
   property p_sync_at_wrap;
      @(posedge hclk) disable iff (!hresetn)
      s_q.sync_o |-> $past(tick) && $past(wrap);
   endproperty
   a_sync_at_wrap: assert property (p_sync_at_wrap) else $error("sync off wrap");
   property p_every_match;
      @(posedge hclk) disable iff (!hresetn)
      (cmp_hit && s_q.ctrl[3:0] == 4'h0) |=> s_q.trig;
   endproperty
   a_every_match: assert property (p_every_match) else $error("missed trigger");
   property p_latch_holds;
      @(posedge hclk) disable iff (!hresetn)
      (s_q.flt_latch && !(s_q.ph_act && s_q.ph_wr && s_q.ph_addr == `OFF_FLT_LIMIT))
         |=> s_q.flt_latch;
   endproperty
   a_latch_holds: assert property (p_latch_holds) else $error("latch dropped");
   property p_half_rate;
      @(posedge hclk) disable iff (!hresetn)
      (tick && s_q.div == 3'h1) |=> !tick;
   endproperty
   a_half_rate: assert property (p_half_rate) else $error("bad divide");
endmodule : pwm_master_time_base_ctrl
`default_nettype wire

// *** verification/pwm_far_side_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pwm_far_side_model (
   // bench controls
   input  wire logic hclk,
   input  wire logic fault_on,
   input  wire logic sync_on,
   input  wire logic pol,
   // device pins
   output logic      ext_sync_in,
   output logic      trig_gen_out_a,
   output logic      trig_gen_out_b,
   output logic      safety_fault_pin
);
   logic [3:0] gap_q;
   logic       pulse;
   // pulled up pin, so it reads high whenever no fault is applied
   assign safety_fault_pin = !fault_on;
   // one-cycle sync every 12 cycles while enabled, shorter than the period
   assign pulse = sync_on && gap_q == 4'h0;
   // sync level follows the chosen polarity, idle at the inactive level
   always_ff @(posedge hclk) begin
      gap_q          <= (!sync_on || gap_q == 4'hb) ? 4'h0 : gap_q + 4'h1;
      ext_sync_in    <= pulse ^ pol;
      trig_gen_out_a <= pulse;
      trig_gen_out_b <= pulse;
   end
endmodule : pwm_far_side_model
`default_nettype wire

// *** verification/pwm_master_time_base_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pwm_tb_consts.svh"
module pwm_master_time_base_ctrl_test;
   import pwm_tb_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, wp_cfg, cpu_idle;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, hrdata, rd;
   logic        s_in, t_a, t_b, s_out, s_oe_n, flt_pin, run, safe, trig, irq;
   logic        fault_on, sync_on, pol;
   int          err_count, total_checks, cyc;
   pwm_master_time_base_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .write_protect_cfg(wp_cfg), .cpu_idle(cpu_idle), .ext_sync_in(s_in),
      .trig_gen_out_a(t_a), .trig_gen_out_b(t_b), .ext_sync_out(s_out),
      .ext_sync_out_oe_n(s_oe_n), .safety_fault_pin(flt_pin), .pwm_run(run),
      .pwm_safe(safe), .special_event_trig(trig), .special_event_irq(irq));
   pwm_far_side_model far (.hclk(hclk), .fault_on(fault_on), .sync_on(sync_on),
      .pol(pol), .ext_sync_in(s_in), .trig_gen_out_a(t_a), .trig_gen_out_b(t_b),
      .safety_fault_pin(flt_pin));
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // one single word transfer; waits on hready, so no latency is assumed
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd);
   endtask : rdc
   task automatic unlock();
      bus(1'b1, `OFF_KEY, {16'h0, `KEY_FIRST});
      bus(1'b1, `OFF_KEY, {16'h0, `KEY_SECOND});
   endtask : unlock
   // counts sync output pulses and special triggers over n cycles
   task automatic win(input int n, input int es, input int et);
      int ns, nt;
      ns = 0;
      nt = 0;
      repeat (n) begin
         @(posedge hclk);
         ns += (s_out === !pol);
         nt += (trig === 1'b1);
      end
      chk("sync pulses", es, ns);
      chk("triggers", et, nt);
   endtask : win
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         finish_test();
      end
   end
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, cpu_idle, fault_on, sync_on, pol} = '0;
      hresetn = 1'b0; wp_cfg = 1'b1; err_count = 0; total_checks = 0; cyc = 0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(`OFF_TB_CTRL, 32'h0);
      rdc(`OFF_PERIOD, 32'hfff8);
      rdc(`OFF_FLT_LIMIT, 32'h4);
      chk("pwm_safe", 1, safe);
      rdc(8'h3c, 32'h0);
      $display("test reset done");
      fault_on <= 1'b1;
      bus(1'b1, `OFF_FLT_LIMIT, 32'h5);
      rdc(`OFF_FLT_LIMIT, 32'h4);
      chk("hresp", 0, hresp);
      unlock();
      bus(1'b1, `OFF_FLT_LIMIT, 32'h6);
      rdc(`OFF_FLT_LIMIT, 32'h6);
      bus(1'b1, `OFF_FLT_LIMIT, 32'h4);
      rdc(`OFF_FLT_LIMIT, 32'h6);
      unlock();
      bus(1'b0, `OFF_TB_CTRL, 32'h0);
      bus(1'b1, `OFF_FLT_LIMIT, 32'h4);
      rdc(`OFF_FLT_LIMIT, 32'h6);
      $display("test protect done");
      // pin released first, or the latch would not clear
      fault_on <= 1'b0;
      unlock();
      bus(1'b1, `OFF_FLT_LIMIT, 32'hc);
      repeat (4) @(posedge hclk);
      chk("pwm_safe", 0, safe);
      // period above any incoming sync period, set while disabled
      bus(1'b1, `OFF_PERIOD, 32'h9);
      bus(1'b1, `OFF_SEV_CMP, 32'h3);
      bus(1'b1, `OFF_CLK_DIV, 32'h1);
      bus(1'b1, `OFF_TB_CTRL, 32'h8d01);
      @(posedge hclk);
      chk("oe_n", 0, s_oe_n);
      chk("pwm_run", 1, run);
      win(80, 4, 2);
      chk("irq", 1, irq);
      bus(1'b1, `OFF_TB_CTRL, 32'had01);
      cpu_idle <= 1'b1;
      win(80, 0, 0);
      cpu_idle <= 1'b0;
      $display("test time base done");
      // partner sync every 12 cycles, inside the 20-cycle period
      bus(1'b1, `OFF_TB_CTRL, 32'h0000);
      sync_on <= 1'b1;
      bus(1'b1, `OFF_TB_CTRL, 32'h8080);
      repeat (24) @(posedge hclk);
      win(96, 0, 8);
      bus(1'b1, `OFF_TB_CTRL, 32'h0000);
      pol <= 1'b1;
      bus(1'b1, `OFF_TB_CTRL, 32'h8280);
      repeat (24) @(posedge hclk);
      win(96, 0, 8);
      bus(1'b1, `OFF_TB_CTRL, 32'h0000);
      bus(1'b1, `OFF_TB_CTRL, 32'h82b0);
      repeat (24) @(posedge hclk);
      win(96, 0, 8);
      // reserved source: nothing resyncs the time base, so it wraps freely
      bus(1'b1, `OFF_TB_CTRL, 32'h0000);
      bus(1'b1, `OFF_TB_CTRL, 32'h8290);
      win(80, 4, 4);
      sync_on <= 1'b0;
      $display("test sync done");
      fault_on <= 1'b1;
      repeat (5) @(posedge hclk);
      chk("pwm_safe", 1, safe);
      chk("pwm_run", 0, run);
      rdc(`OFF_STATUS, 32'h7);
      bus(1'b1, `OFF_TB_CTRL, 32'h0200);
      repeat (3) @(posedge hclk);
      chk("sync idle", 1, s_out);
      chk("oe_n", 1, s_oe_n);
      chk("irq", 0, irq);
      wp_cfg <= 1'b0;
      bus(1'b1, `OFF_OVERRIDE, 32'h1234);
      rdc(`OFF_OVERRIDE, 32'h1234);
      $display("test fault done");
      finish_test();
   end
endmodule : pwm_master_time_base_ctrl_test
`default_nettype wire
